// file: logic/bgat_top.sv
/*
 burst gating of the bit-serial pattern, burst markers, gating output and
 auxiliary output functions, with the pattern FIFO in front of the gate.
 assumes inputs synchronous to clock and settings held steady while used.
*/
`default_nettype none

module bgat_fifo #(
	parameter int W = 1,
	parameter int DEPTH = 32
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (2 ** AW) != DEPTH || W < 1)
	begin : g_chk
		$error("bgat_fifo needs a power-of-two depth and a width of one or more");
	end

	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wr_reg;
	logic [AW:0] rd_reg;
	logic push;
	logic pop;

	assign in_ready = !((wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
	assign out_valid = wr_reg != rd_reg;
	assign out_data = mem[rd_reg[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clock)
	begin
		if (reset || flush)
			wr_reg <= '0;
		else if (push)
			wr_reg <= wr_reg + 1'b1;
	end

	always_ff @(posedge clock)
	begin
		if (reset || flush)
			rd_reg <= '0;
		else if (pop)
			rd_reg <= rd_reg + 1'b1;
	end

	always_ff @(posedge clock)
	begin
		if (push)
			mem[wr_reg[AW-1:0]] <= in_data;
	end
endmodule

module bgat_top #(
	parameter int DATA_W = 1,
	parameter int FIFO_DEPTH = 32
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic seq_burst,
	input wire bgat_pkg::bgat_src_t burst_src,
	input wire bgat_pkg::bgat_seq_t burst_seq,
	input wire logic [1:0] comb,
	input wire bgat_pkg::bgat_cnt_t win_len,
	input wire bgat_pkg::bgat_cnt_t per_len,
	input wire bgat_pkg::bgat_cnt_t mk_dly,
	input wire bgat_pkg::bgat_cnt_t mk_wid,
	input wire bgat_pkg::bgat_cnt_t mk2_dly,
	input wire bgat_pkg::bgat_cnt_t mk2_wid,
	input wire logic aux_in,
	input wire logic aux_route,
	input wire bgat_pkg::bgat_aux_t aux_mode,
	input wire logic [9:0] div_ratio,
	input wire bgat_pkg::bgat_cnt_t sync_per,
	input wire bgat_pkg::bgat_cnt_t sync_pos,
	input wire logic mixed,
	input wire logic [15:0] blk_no,
	input wire logic [15:0] row_no,
	input wire logic [15:0] row_len,
	input wire logic [15:0] row_cnt,
	input wire logic gate_en,
	input wire logic [DATA_W-1:0] pat_data,
	input wire logic pat_valid,
	output logic pat_ready,
	output logic pat_restart,
	output logic [DATA_W-1:0] data_out,
	output logic data_valid,
	output logic gate_out,
	output logic aux_out,
	output logic err_timing,
	output logic burst_active
);
	import bgat_pkg::*;

	if (DATA_W < 1)
	begin : g_chk
		$error("bgat_top needs a data width of one or more");
	end

	function automatic bgat_cnt_t scl(input bgat_cnt_t b, input logic [1:0] s);
		return b << s;
	endfunction

	function automatic bgat_cnt_t qnt(input bgat_cnt_t x, input bgat_cnt_t step);
		return x & ~(step - 1'b1);
	endfunction

	function automatic bgat_cnt_t clamp(input bgat_cnt_t x, input bgat_cnt_t lo,
		input bgat_cnt_t hi);
		return (x < lo) ? lo : ((x > hi) ? hi : x);
	endfunction

	function automatic logic in_win(input bgat_cnt_t p, input bgat_cnt_t d,
		input bgat_cnt_t w);
		return (p >= d) && ((p - d) < w);
	endfunction

	logic [1:0] sh;
	logic is_int;
	logic is_edge;
	logic is_lvl;
	bgat_cnt_t len_step;
	bgat_cnt_t win_q;
	bgat_cnt_t per_q;
	bgat_cnt_t mk_step;
	bgat_cnt_t mk_hi;
	bgat_cnt_t dly1_q;
	bgat_cnt_t wid1_q;
	bgat_cnt_t dly2_q;
	bgat_cnt_t wid2_q;
	logic gate_src;
	logic gate_q_reg;
	logic gate_prev_reg;
	logic rise;
	logic seen_reg;
	bgat_cnt_t bc_reg;
	bgat_cnt_t bc_next;
	bgat_cnt_t pos;
	logic started;
	logic start;
	logic active;
	logic marker1;
	logic marker2;
	logic flush;
	logic f_valid;
	logic f_pop;
	logic [DATA_W-1:0] f_data;
	logic deliver;
	logic mask;
	logic [DATA_W-1:0] data_out_reg;
	logic data_valid_reg;
	logic burst_active_reg;
	logic err_timing_reg;
	bgat_cnt_t pp_reg;
	logic pp_wrap;
	bgat_cnt_t sync_margin;
	bgat_cnt_t sync_sp;
	bgat_cnt_t psync_q;
	logic sync_hit;
	logic [9:0] div_q;
	logic [8:0] dc_reg;
	logic divclk_reg;
	bgat_aux_t aux_mode_reg;
	logic aux_out_reg;
	logic gate_out_reg;

	assign sh = (comb == 2'h3) ? 2'h2 : comb;
	assign is_edge = burst_src == SRC_EDGE;
	assign is_lvl = burst_src == SRC_LEVEL;
	assign is_int = !is_edge && !is_lvl;

	// lengths are forced onto the legal grid so the counters never see odd values
	assign len_step = scl(LEN_STEP, sh);
	assign win_q = clamp(qnt(win_len, len_step), scl(WIN_MIN, sh),
		is_int ? scl(WIN_MAX_INT, sh) : scl(WIN_MAX_EDGE, sh));
	assign per_q = clamp(qnt(per_len, len_step), scl(PER_MIN, sh), scl(PER_MAX, sh));
	assign mk_step = scl(MARK_STEP, sh);
	assign mk_hi = is_int ? per_q - scl(MARK_MARGIN, sh) : '1;
	assign dly1_q = clamp(qnt(mk_dly, mk_step), '0, mk_hi);
	assign wid1_q = clamp(qnt(mk_wid, mk_step), '0, mk_hi);
	assign dly2_q = clamp(qnt(mk2_dly, mk_step), '0, mk_hi);
	assign wid2_q = clamp(qnt(mk2_wid, mk_step), '0, mk_hi);

	// the gate only reaches the burst logic in external burst operation
	assign gate_src = aux_route && seq_burst && !is_int && aux_in;

	always_ff @(posedge clock)
	begin
		if (reset)
			err_timing_reg <= 1'b0;
		else
			err_timing_reg <= !aux_route && aux_in;
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			gate_q_reg <= 1'b0;
			gate_prev_reg <= 1'b0;
		end
		else
		begin
			gate_q_reg <= gate_src;
			gate_prev_reg <= gate_q_reg;
		end
	end

	assign rise = gate_q_reg && !gate_prev_reg;
	assign pos = (!is_int && rise) ? '0 : bc_reg;

	always_comb
	begin
		if (is_int)
			bc_next = (bc_reg >= per_q - 1'b1) ? '0 : bc_reg + 1'b1;
		else
			bc_next = (&pos) ? pos : pos + 1'b1;
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			bc_reg <= '0;
		else
			bc_reg <= bc_next;
	end

	always_ff @(posedge clock)
	begin
		if (reset || is_int || !seq_burst)
			seen_reg <= 1'b0;
		else if (rise)
			seen_reg <= 1'b1;
	end

	assign started = is_int || seen_reg || rise;
	assign start = seq_burst && (is_int ? (bc_reg == '0) : rise);

	always_comb
	begin
		if (!seq_burst)
			active = 1'b0;
		else if (is_lvl)
			active = gate_q_reg;
		else
			active = started && (pos < win_q);
	end

	assign marker1 = seq_burst && started && in_win(pos, dly1_q, wid1_q);
	assign marker2 = seq_burst && started && in_win(pos, dly2_q, wid2_q);

	assign flush = start && (burst_seq == SEQ_RESTART);
	assign pat_restart = flush;

	always_comb
	begin
		if (!seq_burst || burst_seq == SEQ_CONT)
			f_pop = 1'b1;
		else if (flush)
			f_pop = 1'b0;
		else
			f_pop = active;
	end

	bgat_fifo #(
		.W(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.reset(reset),
		.flush(flush),
		.in_valid(pat_valid),
		.in_ready(pat_ready),
		.in_data(pat_data),
		.out_valid(f_valid),
		.out_ready(f_pop),
		.out_data(f_data)
	);

	assign deliver = f_pop && f_valid;
	assign mask = seq_burst && !active;

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			data_out_reg <= '0;
			data_valid_reg <= 1'b0;
			burst_active_reg <= 1'b0;
		end
		else
		begin
			data_out_reg <= (deliver && !mask) ? f_data : '0;
			data_valid_reg <= deliver;
			burst_active_reg <= active;
		end
	end

	// pattern position within the marker period
	assign pp_wrap = deliver && (pp_reg >= sync_per - 1'b1);

	always_ff @(posedge clock)
	begin
		if (reset || flush)
			pp_reg <= '0;
		else if (pp_wrap)
			pp_reg <= '0;
		else if (deliver)
			pp_reg <= pp_reg + 1'b1;
	end

	assign sync_margin = (sh == 2'h0) ? SYNC_MARGIN_1 :
		((sh == 2'h1) ? SYNC_MARGIN_2 : SYNC_MARGIN_4);
	assign sync_sp = (sync_pos == '0) ? bgat_cnt_t'(1) : sync_pos;

	always_comb
	begin
		if (mixed)
			psync_q = CW'(blk_no == 16'h0000 ? 16'h0000 : blk_no - 16'h0001) * CW'(row_cnt)
				* CW'(row_len) + CW'(row_no == 16'h0000 ? 16'h0000 : row_no - 16'h0001)
				* CW'(row_len) + 1'b1;
		else
			psync_q = clamp(qnt(sync_sp - 1'b1, scl(SYNC_STEP, sh)) + 1'b1,
				bgat_cnt_t'(1), sync_per - sync_margin);
	end

	assign sync_hit = deliver && (pp_reg == psync_q - 1'b1);

	assign div_q = (div_ratio < DIV_MIN) ? DIV_MIN :
		((div_ratio > DIV_MAX) ? DIV_MAX : (div_ratio & 10'h3FE));

	// divider restarts with the pattern so its phase tracks the data
	always_ff @(posedge clock)
	begin
		if (reset || flush)
		begin
			dc_reg <= '0;
			divclk_reg <= 1'b0;
		end
		else if (dc_reg >= div_q[9:1] - 1'b1)
		begin
			dc_reg <= '0;
			divclk_reg <= !divclk_reg;
		end
		else
			dc_reg <= dc_reg + 1'b1;
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			aux_mode_reg <= AUX_OFF;
		else if (pp_wrap || flush || aux_mode_reg == AUX_OFF)
			aux_mode_reg <= aux_mode;
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			aux_out_reg <= 1'b0;
		else
			unique case (aux_mode_reg)
				AUX_OFF: aux_out_reg <= 1'b0;
				AUX_DIV: aux_out_reg <= divclk_reg;
				AUX_SYNC: aux_out_reg <= sync_hit;
				AUX_BURST2: aux_out_reg <= marker2;
			endcase
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			gate_out_reg <= 1'b0;
		else
			gate_out_reg <= gate_en && (seq_burst ? marker1 : sync_hit);
	end

	assign data_out = data_out_reg;
	assign data_valid = data_valid_reg;
	assign burst_active = burst_active_reg;
	assign err_timing = err_timing_reg;
	assign aux_out = aux_out_reg;
	assign gate_out = gate_out_reg;

	sequence s_rise;
		seq_burst && is_edge && rise;
	endsequence

	sequence s_count_from_rise;
		##1 (bc_reg == bgat_cnt_t'(1));
	endsequence

	AST_INT_WRAP: assert property (@(posedge clock) disable iff (reset)
		is_int && (bc_reg == per_q - 1'b1) |=> (bc_reg == '0))
		else $error("internal burst counter did not wrap at period end");

	AST_EDGE_START: assert property (@(posedge clock) disable iff (reset)
		s_rise |-> start && active ##0 s_count_from_rise)
		else $error("gate rise did not start a burst");

	AST_LEVEL_MASK: assert property (@(posedge clock) disable iff (reset)
		seq_burst && is_lvl && !gate_q_reg |=> (data_out_reg == '0) && !burst_active_reg)
		else $error("data left the gate while the level gate was low");

	AST_RESTART: assert property (@(posedge clock) disable iff (reset)
		seq_burst && burst_seq == SEQ_RESTART && start |-> pat_restart ##1 (pp_reg == '0))
		else $error("burst start did not rewind the pattern");

	AST_CONSEC_HOLD: assert property (@(posedge clock) disable iff (reset)
		seq_burst && burst_seq == SEQ_CONSEC && !active |-> !f_pop ##1 !data_valid_reg)
		else $error("pattern advanced outside a consecutive burst");

	AST_CONT_ADV: assert property (@(posedge clock) disable iff (reset)
		seq_burst && burst_seq == SEQ_CONT && f_valid |=> data_valid_reg)
		else $error("continuous sequencing stalled the pattern");

	AST_WIN_STEP: assert property (@(posedge clock) disable iff (reset)
		(win_q & (len_step - 1'b1)) == '0 && win_q >= scl(WIN_MIN, sh))
		else $error("window length off the step grid or below minimum");

	AST_GATE_OFF: assert property (@(posedge clock) disable iff (reset)
		!gate_en |=> !gate_out_reg)
		else $error("gating output active while disabled");

	AST_GATE_MARK: assert property (@(posedge clock) disable iff (reset)
		gate_en && seq_burst && marker1 |=> gate_out_reg)
		else $error("burst marker missing on the gating output");

	AST_AUX_OFF: assert property (@(posedge clock) disable iff (reset)
		aux_mode_reg == AUX_OFF |=> !aux_out_reg)
		else $error("aux output active while off");

	AST_AUX_HOLD: assert property (@(posedge clock) disable iff (reset)
		aux_mode_reg != AUX_OFF && !pp_wrap && !flush |=> $stable(aux_mode_reg))
		else $error("aux function changed away from a period boundary");
endmodule

`default_nettype wire

// file: pkg/bgat_pkg.sv
/*
 shared constants and types of the burst gate and auxiliary timing block.
 assumes every length is counted in bits at one bit per clock.
*/
`default_nettype none

package bgat_pkg;
	localparam int CW = 38;
	typedef logic [CW-1:0] bgat_cnt_t;

	typedef enum logic [1:0] {
		SRC_INT = 2'h0,
		SRC_EDGE = 2'h1,
		SRC_LEVEL = 2'h3
	} bgat_src_t;

	typedef enum logic [1:0] {
		SEQ_RESTART = 2'h0,
		SEQ_CONSEC = 2'h1,
		SEQ_CONT = 2'h3
	} bgat_seq_t;

	typedef enum logic [1:0] {
		AUX_OFF = 2'h0,
		AUX_DIV = 2'h1,
		AUX_SYNC = 2'h3,
		AUX_BURST2 = 2'h2
	} bgat_aux_t;

	// single-channel figures, shifted left by comb, by two when comb is 3; sync margins are picked per comb, DIV_MIN/DIV_MAX are not shifted
	localparam bgat_cnt_t WIN_MIN = 38'h00_0000_3200;
	localparam bgat_cnt_t WIN_MAX_INT = 38'h00_7FFF_FF00;
	localparam bgat_cnt_t WIN_MAX_EDGE = 38'h00_8000_0000;
	localparam bgat_cnt_t PER_MIN = 38'h00_0000_6400;
	localparam bgat_cnt_t PER_MAX = 38'h00_8000_0000;
	localparam bgat_cnt_t LEN_STEP = 38'h00_0000_0100;
	localparam bgat_cnt_t MARK_STEP = 38'h00_0000_0008;
	localparam bgat_cnt_t MARK_MARGIN = 38'h00_0000_0080;
	localparam bgat_cnt_t SYNC_STEP = 38'h00_0000_0008;
	localparam bgat_cnt_t SYNC_MARGIN_1 = 38'h00_0000_0087;
	localparam bgat_cnt_t SYNC_MARGIN_2 = 38'h00_0000_011F;
	localparam bgat_cnt_t SYNC_MARGIN_4 = 38'h00_0000_021F;
	localparam logic [9:0] DIV_MIN = 10'h004;
	localparam logic [9:0] DIV_MAX = 10'h200;
endpackage

`default_nettype wire

// file: dv/bgat_pat_model.sv
/*
 pattern generator model that feeds the burst gate FIFO, one bit a word.
 assumes it shares clock and reset with the design.
*/
`default_nettype none

module bgat_pat_model (
	input wire logic clock,
	input wire logic reset,
	input wire logic pat_ready,
	input wire logic pat_restart,
	output logic pat_valid,
	output logic pat_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] idx_reg;
	always_ff @(posedge clock)
	begin
		if (reset || pat_restart)
			idx_reg <= 8'h00;
		else if (pat_valid && pat_ready)
			idx_reg <= idx_reg + 8'h01;
	end
	assign pat_valid = !reset;
	// inverse data while no word is offered
	assign pat_data = pat_valid ? idx_reg[1] : ~idx_reg[1];
endmodule

`default_nettype wire

// file: dv/bgat_top_bench.sv
/*
 self-checking bench of the burst gate: level, edge and internal gating,
 markers, aux output modes and the pattern FIFO.
 assumes a 250 MHz clock and a synchronous active-high reset.
*/
`default_nettype none

module bgat_top_bench import bgat_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock, reset, seq_burst, aux_in, aux_route, gate_en, mixed;
	logic pat_valid, pat_data, pat_ready, pat_restart, data_out, data_valid;
	logic gate_out, aux_out, err_timing, burst_active;
	bgat_src_t burst_src;
	bgat_seq_t burst_seq;
	bgat_aux_t aux_mode;
	logic [1:0] comb;
	bgat_cnt_t win_len, per_len, mk_dly, mk_wid, mk2_dly, mk2_wid, sync_per, sync_pos;
	logic [9:0] div_ratio;
	logic [15:0] blk_no, row_no, row_len, row_cnt;
	int err_total;
	int cmp_count;
	int cnt [8];

	bgat_top dut (.clock, .reset, .seq_burst, .burst_src, .burst_seq, .comb, .win_len,
		.per_len, .mk_dly, .mk_wid, .mk2_dly, .mk2_wid, .aux_in, .aux_route, .aux_mode,
		.div_ratio, .sync_per, .sync_pos, .mixed, .blk_no, .row_no, .row_len, .row_cnt,
		.gate_en, .pat_data, .pat_valid, .pat_ready, .pat_restart, .data_out, .data_valid,
		.gate_out, .aux_out, .err_timing, .burst_active);

	bgat_pat_model gen (.clock, .reset, .pat_ready, .pat_restart, .pat_valid, .pat_data);

	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		#400000;
		err_total++;
		wrap_up();
	end

	task automatic chk(input string name, input int exp, input int got);
		cmp_count++;
		if (exp !== got)
		begin
			err_total++;
			$display("wrong value %s expected %0d seen %0d", name, exp, got);
		end
	endtask

	task automatic rst();
		reset = 1'b1;
		repeat (6) @(posedge clock);
		#1 reset = 1'b0;
		repeat (40) @(posedge clock);
		#1;
	endtask

	task automatic lens(input bgat_cnt_t w, p, d, m, d2, m2);
		win_len = w;
		per_len = p;
		mk_dly = d;
		mk_wid = m;
		mk2_dly = d2;
		mk2_wid = m2;
	endtask

	// counts output activity over n cycles, gate input high for the first hi
	task automatic measure(input int n, input int hi);
		logic ax_prev;
		cnt = '{default: 0};
		ax_prev = aux_out;
		for (int i = 0; i < n; i++)
		begin
			aux_in = (i < hi);
			@(posedge clock);
			#1;
			cnt[0] += (burst_active === 1'b1);
			cnt[1] += (gate_out === 1'b1);
			cnt[2] += (aux_out === 1'b1);
			cnt[3] += (aux_out !== ax_prev);
			cnt[4] += (data_valid === 1'b1);
			cnt[5] += (pat_restart === 1'b1);
			cnt[6] += (err_timing === 1'b1);
			cnt[7] += (data_out === 1'b1);
			ax_prev = aux_out;
		end
		aux_in = 1'b0;
	endtask

	initial
	begin
		err_total = 0;
		cmp_count = 0;
		{reset, seq_burst, aux_in, aux_route, gate_en, mixed} = 6'h36;
		burst_src = SRC_LEVEL;
		burst_seq = SEQ_CONSEC;
		aux_mode = AUX_OFF;
		comb = 2'h0;
		div_ratio = 10'h008;
		{blk_no, row_no, row_len, row_cnt} = 64'h0002_0003_0010_0004;
		sync_per = 38'h00_0000_0200;
		sync_pos = 38'h00_0000_0009;
		lens(38'h0, 38'h0, 38'h0, 38'h0, 38'h0, 38'h0);
		#1;
		rst();
		measure(100, 0);
		chk("fifo_ready", 0, pat_ready === 1'b1);
		chk("held_valid", 0, cnt[4]);
		chk("aux_off", 0, cnt[2]);
		measure(210, 200);
		chk("level_active", 200, cnt[0]);
		chk("level_valid", 200, cnt[4]);
		$display("test level_consecutive finished");
		burst_seq = SEQ_CONT;
		aux_route = 1'b0;
		aux_mode = AUX_DIV;
		measure(20, 0);
		measure(200, 50);
		chk("unrouted_active", 0, cnt[0]);
		chk("err_timing", 50, cnt[6]);
		chk("masked_data", 0, cnt[7]);
		chk("cont_valid", 200, cnt[4]);
		chk("div_toggles", 50, cnt[3]);
		$display("test continuous_div finished");
		burst_src = SRC_INT;
		burst_seq = SEQ_RESTART;
		aux_route = 1'b1;
		aux_mode = AUX_BURST2;
		comb = 2'h1;
		lens(38'h3200, 38'h6400, 38'h8, 38'h18, 38'h0, 38'h28);
		rst();
		measure(51200, 5000);
		chk("active_2ch", 25600, cnt[0]);
		chk("marker_2ch", 16, cnt[1]);
		chk("marker2_2ch", 32, cnt[2]);
		chk("restarts_2ch", 1, cnt[5]);
		$display("test internal_2ch finished");
		comb = 2'h0;
		lens(38'h332C, 38'h6464, 38'h8, 38'h14, 38'h0, 38'h2C);
		rst();
		measure(25600, 0);
		chk("active_1ch", 13056, cnt[0]);
		chk("marker_1ch", 16, cnt[1]);
		chk("marker2_1ch", 40, cnt[2]);
		chk("restarts_1ch", 1, cnt[5]);
		$display("test internal_1ch finished");
		burst_src = SRC_EDGE;
		gate_en = 1'b0;
		lens(38'h3200, 38'h6400, 38'h0, 38'h10, 38'h0, 38'h0);
		rst();
		measure(13000, 20);
		chk("edge_active", 12800, cnt[0]);
		chk("gate_disabled", 0, cnt[1]);
		chk("edge_restart", 1, cnt[5]);
		$display("test edge finished");
		seq_burst = 1'b0;
		gate_en = 1'b1;
		aux_mode = AUX_SYNC;
		rst();
		measure(1024, 0);
		chk("sync_gate", 2, cnt[1]);
		chk("sync_aux", 2, cnt[2]);
		comb = 2'h1;
		sync_per = 38'h00_0000_0400;
		sync_pos = 38'h00_0000_03FF;
		rst();
		measure(800, 0);
		chk("sync_clamp_aux", 1, cnt[2]);
		chk("sync_clamp_gate", 1, cnt[1]);
		comb = 2'h0;
		mixed = 1'b1;
		sync_per = 38'h00_0000_0080;
		rst();
		measure(1024, 0);
		chk("mixed_gate", 8, cnt[1]);
		$display("test period_marker finished");
		wrap_up();
	end
endmodule

`default_nettype wire
